/* File: design/seg_bus_pkg.sv */
// Purpose: Shared constants for the segmented local packet bus signalling block.
// Assumes: One clock domain, four segments of 128-bit data.
// Notes: Every offset, width, reset value and count used by the design lives here.
package seg_bus_pkg;
    // Number of segments on the bus, zero through three.
    localparam int SEGMENTS = 4;
    // Data bits carried by one segment in one transfer.
    localparam int SEG_DATA_W = 128;
    // Width of the per-segment empty byte count.
    localparam int EMPTY_W = 4;
    // Low empty bits that are forced to zero on an errored end.
    localparam int EMPTY_LOW_W = 3;
    // Depth of the transmit buffer in words.
    localparam int FIFO_DEPTH = 8;
    // Free words still held back when ready drops, in cycles of user reaction time.
    localparam int TX_SLACK_CYCLES = 2;
    // Value of every state bit after reset.
    localparam logic STATE_RESET = 1'b0;
endpackage

/* File: design/segmented_packet_bus_signalling.sv */
// Purpose: Receive qualification and transmit back-pressure of the segmented local packet bus.
// Assumes: Receive words arrive from the MAC in the same clock domain; user logic shares clk.
// Notes: The transmit buffer and the top module share this file; the buffer has its own module.
`timescale 1ns/1ps
`default_nettype none

// Synchronous buffer with honest full and empty and a fill level output.
module seg_word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Number of words held.
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    // All buffer state: pointers with a wrap bit, and the storage itself.
    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
        logic [DEPTH-1:0][WIDTH-1:0] mem;
    } fifo_state_t;

    fifo_state_t st_reg;
    fifo_state_t st_next;

    // Level is the pointer distance; the wrap bit tells full from empty.
    assign level = st_reg.wr - st_reg.rd;
    assign in_ready = (level != (AW+1)'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data = st_reg.mem[st_reg.rd[AW-1:0]];

    // Next state: write on an accepted push, advance the read side on a pop.
    always_comb begin
        st_next = st_reg;
        if (in_valid && in_ready) begin
            st_next.mem[st_reg.wr[AW-1:0]] = in_data;
            st_next.wr = st_reg.wr + 1'b1;
        end
        if (out_valid && out_ready) begin
            st_next.rd = st_reg.rd + 1'b1;
        end
    end

    // State register; storage is cleared too so no unknown word can ever leak out.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

module segmented_packet_bus_signalling #(
    parameter int SEGS = seg_bus_pkg::SEGMENTS,
    parameter int DW = seg_bus_pkg::SEG_DATA_W,
    parameter int MW = seg_bus_pkg::EMPTY_W,
    parameter int DEPTH = seg_bus_pkg::FIFO_DEPTH,
    parameter int SLACK = seg_bus_pkg::TX_SLACK_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Receive words from the MAC, one lane per segment.
    input wire logic [SEGS-1:0] rx_in_ena,
    input wire logic [SEGS*DW-1:0] rx_in_data,
    input wire logic [SEGS-1:0] rx_in_sop,
    input wire logic [SEGS-1:0] rx_in_eop,
    input wire logic [SEGS-1:0] rx_in_err,
    input wire logic [SEGS*MW-1:0] rx_in_mty,
    // Receive segmented bus toward user logic.
    output logic [SEGS-1:0] rx_ena_out,
    output logic [SEGS*DW-1:0] rx_data_out,
    output logic [SEGS-1:0] rx_sop_out,
    output logic [SEGS-1:0] rx_eop_out,
    output logic [SEGS-1:0] rx_err_out,
    output logic [SEGS*MW-1:0] rx_mty_out,
    // Transmit segmented bus from user logic.
    input wire logic [SEGS-1:0] tx_ena_in,
    input wire logic [SEGS*DW-1:0] tx_data_in,
    input wire logic [SEGS-1:0] tx_sop_in,
    input wire logic [SEGS-1:0] tx_eop_in,
    input wire logic [SEGS*MW-1:0] tx_mty_in,
    output logic tx_rdy_out,
    output logic tx_ovf_out,
    // Buffered transmit words toward the MAC.
    output logic tx_mac_valid,
    input wire logic tx_mac_ready,
    output logic [SEGS-1:0] tx_mac_ena,
    output logic [SEGS*DW-1:0] tx_mac_data,
    output logic [SEGS-1:0] tx_mac_sop,
    output logic [SEGS-1:0] tx_mac_eop,
    output logic [SEGS*MW-1:0] tx_mac_mty
);
    localparam int LW = $clog2(DEPTH) + 1;
    // Buffered word: enable, start and end flags per segment, then the empty counts and the data.
    localparam int FW = 3 * SEGS + SEGS * (DW + MW);
    // Ready drops while SLACK or fewer words are free, so SLACK late pushes still fit.
    localparam logic [LW-1:0] RDY_LIMIT = LW'(DEPTH - SLACK);

    // All block state: registered receive outputs, packet tracking and the overflow flag.
    typedef struct packed {
        logic [SEGS-1:0] ena;
        logic [SEGS-1:0] sop;
        logic [SEGS-1:0] eop;
        logic [SEGS-1:0] err;
        logic [SEGS*DW-1:0] data;
        logic [SEGS*MW-1:0] mty;
        logic [SEGS-1:0] open_before;
        logic open;
        logic ovf;
    } blk_state_t;

    blk_state_t st_reg;
    blk_state_t st_next;

    // Transmit buffer signals.
    logic push;
    logic fifo_in_ready;
    logic [LW-1:0] fifo_level;
    logic [FW-1:0] fifo_out;

    // Any enabled segment makes the cycle one buffered word.
    assign push = |tx_ena_in;

    // Next state: segments are walked in order 0..3, as packets flow through them.
    always_comb begin
        logic open_v;
        open_v = st_reg.open;
        st_next = st_reg;
        for (int i = 0; i < SEGS; i++) begin
            st_next.open_before[i] = open_v;
            st_next.ena[i] = rx_in_ena[i];
            // Idle segments show zeros so nothing stale looks meaningful.
            st_next.data[i*DW +: DW] = rx_in_ena[i] ? rx_in_data[i*DW +: DW] : '0;
            st_next.sop[i] = rx_in_ena[i] & rx_in_sop[i];
            if (st_next.sop[i]) begin
                open_v = 1'b1;
            end
            // An end with no open packet is dropped rather than passed as a second end.
            st_next.eop[i] = rx_in_ena[i] & rx_in_eop[i] & open_v;
            st_next.err[i] = st_next.eop[i] & rx_in_err[i];
            st_next.mty[i*MW +: MW] = st_next.eop[i] ? rx_in_mty[i*MW +: MW] : '0;
            if (st_next.err[i]) begin
                st_next.mty[i*MW +: seg_bus_pkg::EMPTY_LOW_W] = '0;
            end
            if (st_next.eop[i]) begin
                open_v = 1'b0;
            end
        end
        st_next.open = open_v;
        // Overflow is only ever set here; only sys_rst clears it.
        if (push && !fifo_in_ready) begin
            st_next.ovf = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Receive outputs straight from the state register.
    assign rx_ena_out = st_reg.ena;
    assign rx_data_out = st_reg.data;
    assign rx_sop_out = st_reg.sop;
    assign rx_eop_out = st_reg.eop;
    assign rx_err_out = st_reg.err;
    assign rx_mty_out = st_reg.mty;

    // Ready also stays low after an overflow, since the path needs a reset anyway.
    assign tx_rdy_out = (fifo_level < RDY_LIMIT) && !st_reg.ovf;
    assign tx_ovf_out = st_reg.ovf;

    // The buffer lets the MAC stall while user logic keeps sending within its slack.
    seg_word_fifo #(
        .WIDTH(FW),
        .DEPTH(DEPTH)
    ) tx_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data({tx_ena_in, tx_sop_in, tx_eop_in, tx_mty_in, tx_data_in}),
        .out_valid(tx_mac_valid),
        .out_ready(tx_mac_ready),
        .out_data(fifo_out),
        .level(fifo_level)
    );

    assign {tx_mac_ena, tx_mac_sop, tx_mac_eop, tx_mac_mty, tx_mac_data} = fifo_out;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Overflow, once raised, holds for the four following cycles.
    sequence s_ovf_held;
        tx_ovf_out [*4];
    endsequence

    property p_ovf_sticky;
        $rose(tx_ovf_out) |=> s_ovf_held;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag dropped");

    property p_ovf_cause;
        push && !fifo_in_ready |=> tx_ovf_out && !tx_rdy_out;
    endproperty
    a_ovf_cause: assert property (p_ovf_cause) else $error("push into full buffer not flagged");

    property p_rdy_room;
        tx_rdy_out |-> (fifo_level + LW'(SLACK)) <= LW'(DEPTH);
    endproperty
    a_rdy_room: assert property (p_rdy_room) else $error("ready high without slack room");

    for (genvar g = 0; g < SEGS; g++) begin : g_seg_check
        property p_eop_qual;
            rx_eop_out[g] |-> rx_ena_out[g];
        endproperty
        a_eop_qual: assert property (p_eop_qual) else $error("end without enable");

        property p_err_qual;
            rx_err_out[g] |-> rx_ena_out[g] && rx_eop_out[g] && $past(rx_in_err[g]);
        endproperty
        a_err_qual: assert property (p_err_qual) else $error("error outside a qualified end");

        property p_clean_end;
            rx_eop_out[g] && !rx_err_out[g] |-> !$past(rx_in_err[g]) &&
                rx_mty_out[g*MW +: MW] == $past(rx_in_mty[g*MW +: MW]);
        endproperty
        a_clean_end: assert property (p_clean_end) else $error("clean end lost error or count");

        property p_mty_low;
            rx_err_out[g] && rx_ena_out[g] |-> rx_mty_out[g*MW +: seg_bus_pkg::EMPTY_LOW_W] == '0;
        endproperty
        a_mty_low: assert property (p_mty_low) else $error("errored empty low bits not zero");

        property p_idle;
            !rx_in_ena[g] |=> !rx_ena_out[g] && !rx_sop_out[g] && rx_data_out[g*DW +: DW] == '0;
        endproperty
        a_idle: assert property (p_idle) else $error("idle segment shows activity");

        property p_end_after_start;
            rx_eop_out[g] |-> rx_sop_out[g] || st_reg.open_before[g];
        endproperty
        a_end_after_start: assert property (p_end_after_start) else $error("end with no open packet");
    end
endmodule

`default_nettype wire

/* File: test/seg_user_source.sv */
// Purpose: User-side transmit source for the segmented local packet bus.
// Assumes: Shares clk with the block and reacts to ready one edge late.
// Notes: Idle data, start, end and empty lines toggle while enable stays low, so a stale word never looks like a fresh one.
`timescale 1ns/1ps
`default_nettype none
module seg_user_source (
    // Clock, reset and control.
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic go,
    input wire logic ignore_rdy,
    // Back-pressure from the block.
    input wire logic tx_rdy_out,
    // Transmit bus toward the block.
    output logic [3:0] tx_ena_in,
    output logic [511:0] tx_data_in,
    output logic [3:0] tx_sop_in,
    output logic [3:0] tx_eop_in,
    output logic [15:0] tx_mty_in,
    // Words presented so far.
    output logic [31:0] sent
);
    // One whole packet a word; its sequence number fills every lane and the empty counts.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_ena_in <= 4'h0;
            tx_data_in <= '0;
            tx_sop_in <= 4'h0;
            tx_eop_in <= 4'h0;
            tx_mty_in <= 16'h0000;
            sent <= 32'h0;
        end else if (go && (tx_rdy_out || ignore_rdy)) begin
            tx_ena_in <= 4'hf;
            tx_data_in <= {16{sent}};
            tx_sop_in <= 4'h1;
            tx_eop_in <= 4'h8;
            tx_mty_in <= sent[15:0];
            sent <= sent + 32'h1;
        end else begin
            // Released data, start, end and empty lines change every cycle; enable is held low.
            tx_ena_in <= 4'h0;
            tx_data_in <= ~tx_data_in;
            tx_sop_in <= ~tx_sop_in;
            tx_eop_in <= ~tx_eop_in;
            tx_mty_in <= ~tx_mty_in;
        end
    end
endmodule
`default_nettype wire

/* File: test/segmented_packet_bus_signalling_test.sv */
// Purpose: Self-checking bench for the segmented packet bus signalling block.
// Assumes: Default parameters; outputs are sampled 1 ns after the edge.
// Notes: Expected values come from the bus rules, never from the block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module segmented_packet_bus_signalling_test;
    // Run bookkeeping.
    int err_count = 0;
    int samples_checked = 0;
    // Stimulus, all given a value at time zero.
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] rx_in_ena = 4'h0, rx_in_sop = 4'h0, rx_in_eop = 4'h0, rx_in_err = 4'h0;
    logic [511:0] rx_in_data = {4{128'h0123456789abcdef0011223344556677}};
    logic [15:0] rx_in_mty = 16'h0000;
    logic tx_mac_ready = 1'b0, go = 1'b0, ignore_rdy = 1'b0;
    // Observed outputs and partner lines.
    logic [3:0] rx_ena_out, rx_sop_out, rx_eop_out, rx_err_out, tx_ena_in, tx_sop_in, tx_eop_in, tx_mac_sop;
    logic [511:0] rx_data_out, tx_data_in, tx_mac_data;
    logic [15:0] rx_mty_out, tx_mty_in, tx_mac_mty;
    logic [3:0] tx_mac_ena, tx_mac_eop;
    logic tx_rdy_out, tx_ovf_out, tx_mac_valid;
    logic [31:0] sent;

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    segmented_packet_bus_signalling u_segmented_packet_bus_signalling (
        .clk(clk), .sys_rst(sys_rst), .rx_in_ena(rx_in_ena), .rx_in_data(rx_in_data),
        .rx_in_sop(rx_in_sop), .rx_in_eop(rx_in_eop), .rx_in_err(rx_in_err), .rx_in_mty(rx_in_mty),
        .rx_ena_out(rx_ena_out), .rx_data_out(rx_data_out), .rx_sop_out(rx_sop_out),
        .rx_eop_out(rx_eop_out), .rx_err_out(rx_err_out), .rx_mty_out(rx_mty_out),
        .tx_ena_in(tx_ena_in), .tx_data_in(tx_data_in), .tx_sop_in(tx_sop_in), .tx_eop_in(tx_eop_in),
        .tx_mty_in(tx_mty_in), .tx_rdy_out(tx_rdy_out), .tx_ovf_out(tx_ovf_out),
        .tx_mac_valid(tx_mac_valid), .tx_mac_ready(tx_mac_ready), .tx_mac_ena(tx_mac_ena),
        .tx_mac_data(tx_mac_data), .tx_mac_sop(tx_mac_sop), .tx_mac_eop(tx_mac_eop), .tx_mac_mty(tx_mac_mty));

    seg_user_source u_seg_user_source (
        .clk(clk), .sys_rst(sys_rst), .go(go), .ignore_rdy(ignore_rdy), .tx_rdy_out(tx_rdy_out),
        .tx_ena_in(tx_ena_in), .tx_data_in(tx_data_in), .tx_sop_in(tx_sop_in),
        .tx_eop_in(tx_eop_in), .tx_mty_in(tx_mty_in), .sent(sent));

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Holds reset for six cycles, then checks the idle transmit state.
    task automatic do_reset();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("tx_ovf_out", 1'b0, tx_ovf_out)
        `CHK("tx_rdy_out", 1'b1, tx_rdy_out)
    endtask

    // Presents one receive word for one cycle; returns once its answer has settled.
    task automatic rx_step(input logic [3:0] e, s, o, r, input logic [15:0] m);
        @(posedge clk);
        rx_in_ena <= e;
        rx_in_sop <= s;
        rx_in_eop <= o;
        rx_in_err <= r;
        rx_in_mty <= m;
        @(posedge clk);
        rx_in_ena <= 4'h0;
        rx_in_sop <= 4'h0;
        rx_in_eop <= 4'h0;
        #1;
    endtask

    // Packet opens in segment 0 and ends in error in segment 1.
    task automatic rx_walk();
        rx_step(4'h3, 4'h1, 4'h2, 4'h2, 16'h00f0);
        `CHK("rx_ena_out", 4'h3, rx_ena_out)
        `CHK("rx_sop_out", 4'h1, rx_sop_out)
        `CHK("rx_eop_out", 4'h2, rx_eop_out)
        `CHK("rx_err_out", 4'h2, rx_err_out)
        `CHK("rx_mty_out", 16'h0080, rx_mty_out)
        `CHK("rx_data_out", rx_in_data[255:0], rx_data_out[255:0])
        `CHK("rx_data_out", 256'h0, rx_data_out[511:256])
        $display("done rx_walk");
    endtask

    // A clean single-word packet in each segment in turn.
    task automatic rx_segments();
        for (int s = 0; s < 4; s++) begin
            rx_step(4'h1 << s, 4'h1 << s, 4'h1 << s, 4'h0, 16'h0005 << (4 * s));
            `CHK("rx_eop_out", 4'h1 << s, rx_eop_out)
            `CHK("rx_err_out", 4'h0, rx_err_out)
            `CHK("rx_mty_out", 16'h0005 << (4 * s), rx_mty_out)
        end
        $display("done rx_segments");
    endtask

    // An end with no open packet is dropped; a packet spanning two cycles is not.
    task automatic rx_orphan_span();
        rx_step(4'h1, 4'h0, 4'h1, 4'h1, 16'h0007);
        `CHK("rx_eop_out", 4'h0, rx_eop_out)
        `CHK("rx_ena_out", 4'h1, rx_ena_out)
        `CHK("rx_err_out", 4'h0, rx_err_out)
        `CHK("rx_mty_out", 16'h0000, rx_mty_out)
        rx_step(4'h8, 4'h8, 4'h0, 4'h0, 16'h0000);
        rx_step(4'h1, 4'h0, 4'h1, 4'h1, 16'h000c);
        `CHK("rx_eop_out", 4'h1, rx_eop_out)
        `CHK("rx_mty_out", 16'h0008, rx_mty_out)
        // Orphan end in segment 0, then a whole packet in segments 1 and 2 of the same cycle.
        rx_step(4'hf, 4'h2, 4'h5, 4'h0, 16'h0305);
        `CHK("rx_sop_out", 4'h2, rx_sop_out)
        `CHK("rx_eop_out", 4'h4, rx_eop_out)
        `CHK("rx_err_out", 4'h0, rx_err_out)
        `CHK("rx_mty_out", 16'h0300, rx_mty_out)
        $display("done rx_orphan_span");
    endtask

    // Stalled sink: the user stops when ready drops, then the buffer drains in order.
    task automatic tx_backpressure();
        int n;
        n = seg_bus_pkg::FIFO_DEPTH - seg_bus_pkg::TX_SLACK_CYCLES + 1;
        @(posedge clk);
        go <= 1'b1;
        repeat (20) @(posedge clk);
        #1;
        `CHK("tx_rdy_out", 1'b0, tx_rdy_out)
        `CHK("tx_ovf_out", 1'b0, tx_ovf_out)
        `CHK("sent", n, sent)
        @(posedge clk);
        go <= 1'b0;
        tx_mac_ready <= 1'b1;
        for (int i = 0; i < n; i++) begin
            #1;
            `CHK("tx_mac_data", i, tx_mac_data[31:0])
            `CHK("tx_mac_mty", i, tx_mac_mty)
            `CHK("tx_mac_ena", 4'hf, tx_mac_ena)
            `CHK("tx_mac_sop", 4'h1, tx_mac_sop)
            `CHK("tx_mac_eop", 4'h8, tx_mac_eop)
            @(posedge clk);
        end
        #1;
        `CHK("tx_mac_valid", 1'b0, tx_mac_valid)
        @(posedge clk);
        tx_mac_ready <= 1'b0;
        $display("done tx_backpressure");
    endtask

    // The user ignores ready: overflow rises, sticks, and only reset clears it.
    task automatic tx_overflow();
        @(posedge clk);
        go <= 1'b1;
        ignore_rdy <= 1'b1;
        repeat (12) @(posedge clk);
        #1;
        `CHK("tx_ovf_out", 1'b1, tx_ovf_out)
        `CHK("tx_rdy_out", 1'b0, tx_rdy_out)
        @(posedge clk);
        go <= 1'b0;
        ignore_rdy <= 1'b0;
        do_reset();
        $display("done tx_overflow");
    endtask

    // Main sequence.
    initial begin
        do_reset();
        rx_walk();
        rx_segments();
        rx_orphan_span();
        tx_backpressure();
        tx_overflow();
        stop_test();
    end

    // Watchdog well beyond the fewer than 100 cycles the tests need.
    initial begin
        #50000;
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire
